// [rss_reset_strap_sampler.sv]
/*
  rss_reset_strap_sampler: captures the strap pins at reset release, steers
  boot, interrupt, link width and config write policy, switches the strap
  pulls and hands the pins back to their normal use.
  Assumes pins and strobes synchronous to clk_in, register reads answered
  one cycle after the read strobe, and pad logic that resolves the pulls.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
// What this block does
// - watch strap pins while reset is held
// - reset-time pulls give undriven pins defaults
// - capture straps at reset deassertion edge
// - hold captured level as strap configuration
// - return strap pins to normal use shortly
// - boot strap 0 boots at once
// - boot strap 1 idles until outside boot
// - irq strap 0 disabled level-sensitive interrupts
// - irq strap 1 enabled edge-sensitive interrupts
// - link strap selects 1-bit or 4-bit input
// - write strap: one-time or always writable configs
// - pulls follow reset, then pull-up or drive
// - id-dependent pulls only on processor id zero
`timescale 1ns/1ps
module rss_reset_strap_sampler
    import rss_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [6:0] strap_pin_in,
    output logic [6:0] strap_pin_out,
    output logic [6:0] strap_pin_oe_out,
    output logic [6:0] pullup_en_out,
    output logic [6:0] pulldown_en_out,
    input wire logic [2:0] proc_id_in,
    input wire logic [6:0] func_data_in,
    input wire logic [6:0] func_oe_in,
    input wire logic ext_boot_in,
    output logic core_run_out,
    output logic boot_source_strap_out,
    output logic irq_enable_out,
    output logic irq_edge_out,
    output logic link_rx_width_strap_out,
    output logic config_write_policy_strap_out,
    output logic test_strap_fault_out,
    output logic [31:0] system_config_reg_out,
    output logic [31:0] sdram_config_reg_out,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out
);

    // ==========================================================
    // state
    typedef struct packed {
        rss_phase_t phase;
        logic [2:0] cnt;
        logic [6:0] straps;
        logic run;
        logic [31:0] sys_cfg;
        logic sys_written;
        logic [31:0] sdr_cfg;
        logic sdr_written;
        logic [31:0] rdata;
        logic [6:0] pin_out;
        logic [6:0] pin_oe;
        logic test_fault;
    } rss_state_t;

    rss_state_t st_ff;
    rss_state_t nxt_st;
    logic [6:0] pullup_ff;
    logic [6:0] pulldown_ff;
    logic [6:0] nxt_pullup;
    logic [6:0] nxt_pulldown;
    logic id_zero;

    // a config register takes a write if always writable or not yet written
    function automatic logic write_allowed(input logic policy, input logic written);
        write_allowed = policy | ~written;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 32'h0000_0000;
        case (st_ff.phase)
            PH_RESET: begin
                // first edge after release latches the pin levels
                nxt_st.straps = strap_pin_in;
                nxt_st.test_fault = ((strap_pin_in ^ STRAP_DEFAULT) & TEST_STRAP_MASK) != 7'h00;
                nxt_st.cnt = 3'h0;
                nxt_st.phase = PH_HANDBACK;
            end
            PH_HANDBACK: begin
                if (st_ff.cnt == HANDBACK_LAST) begin
                    nxt_st.phase = PH_RUN;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 3'h1;
                end
            end
            PH_RUN: begin
                nxt_st.phase = PH_RUN;
            end
            default: begin
                nxt_st.phase = PH_RESET;
            end
        endcase
        // boot control
        if (nxt_st.phase == PH_RUN) begin
            if (!st_ff.straps[BOOT_MEMORY_SELECT_PIN]) begin
                nxt_st.run = 1'b1;
            end else if (ext_boot_in && st_ff.phase == PH_RUN) begin
                nxt_st.run = 1'b1;
            end
        end
        // pins: released only in normal operation
        if (nxt_st.phase == PH_RUN) begin
            nxt_st.pin_out = func_data_in;
            nxt_st.pin_oe = RUN_DRIVEN_MASK | (func_oe_in & ~RUN_DRIVEN_MASK);
        end else begin
            nxt_st.pin_out = 7'h00;
            nxt_st.pin_oe = 7'h00;
        end
        // register writes
        if (wr_in && st_ff.phase == PH_RUN) begin
            if (addr_in == SYSTEM_CONFIG_OFFSET &&
                write_allowed(st_ff.straps[BUS_LOCK_PIN], st_ff.sys_written)) begin
                nxt_st.sys_cfg = wdata_in;
                nxt_st.sys_written = 1'b1;
            end
            if (addr_in == SDRAM_CONFIG_OFFSET &&
                write_allowed(st_ff.straps[BUS_LOCK_PIN], st_ff.sdr_written)) begin
                nxt_st.sdr_cfg = wdata_in;
                nxt_st.sdr_written = 1'b1;
            end
        end
        // register reads, unmapped reads return zero
        if (rd_in) begin
            case (addr_in)
                STATUS_OFFSET: begin
                    nxt_st.rdata = {21'h000000, st_ff.sdr_written, st_ff.sys_written,
                                    st_ff.run, st_ff.phase == PH_RUN, st_ff.straps};
                end
                SYSTEM_CONFIG_OFFSET: begin
                    nxt_st.rdata = st_ff.sys_cfg;
                end
                SDRAM_CONFIG_OFFSET: begin
                    nxt_st.rdata = st_ff.sdr_cfg;
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff.phase <= PH_RESET;
            st_ff.cnt <= 3'h0;
            st_ff.straps <= STRAP_DEFAULT;
            st_ff.run <= 1'b0;
            st_ff.sys_cfg <= SYSTEM_CONFIG_RESET;
            st_ff.sys_written <= 1'b0;
            st_ff.sdr_cfg <= SDRAM_CONFIG_RESET;
            st_ff.sdr_written <= 1'b0;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.pin_out <= 7'h00;
            st_ff.pin_oe <= 7'h00;
            st_ff.test_fault <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // pull control: follows the phase and the processor id each clock
    assign id_zero = (proc_id_in == 3'h0);

    always_comb begin
        if (st_ff.phase == PH_RUN || st_ff.phase == PH_HANDBACK) begin
            nxt_pullup = RUN_PULLUP_MASK;
            nxt_pulldown = 7'h00;
        end else begin
            nxt_pullup = RST_PULLUP_MASK;
            nxt_pulldown = RST_PULLDOWN_MASK;
        end
        if (!id_zero) begin
            nxt_pullup = nxt_pullup & ~ID_DEPENDENT_MASK;
            nxt_pulldown = nxt_pulldown & ~ID_DEPENDENT_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        pullup_ff <= nxt_pullup;
        pulldown_ff <= nxt_pulldown;
    end

    // ==========================================================
    // outputs
    assign strap_pin_out = st_ff.pin_out;
    assign strap_pin_oe_out = st_ff.pin_oe;
    assign pullup_en_out = pullup_ff;
    assign pulldown_en_out = pulldown_ff;
    assign core_run_out = st_ff.run;
    assign boot_source_strap_out = st_ff.straps[BOOT_MEMORY_SELECT_PIN];
    assign irq_enable_out = st_ff.straps[BUS_MASTER_PIN];
    assign irq_edge_out = st_ff.straps[BUS_MASTER_PIN];
    assign link_rx_width_strap_out = st_ff.straps[TIMER0_EXPIRED_PIN];
    assign config_write_policy_strap_out = st_ff.straps[BUS_LOCK_PIN];
    // a test strap latched away from default is flagged
    assign test_strap_fault_out = st_ff.test_fault;
    assign system_config_reg_out = st_ff.sys_cfg;
    assign sdram_config_reg_out = st_ff.sdr_cfg;
    assign rdata_out = st_ff.rdata;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    property p_capture;
        (st_ff.phase == PH_RESET && nrst_in) |=> (st_ff.straps == $past(strap_pin_in));
    endproperty
    a_capture: assert property (p_capture) else $error("straps not captured");

    property p_hold;
        (st_ff.phase != PH_RESET) |=> $stable(st_ff.straps);
    endproperty
    a_hold: assert property (p_hold) else $error("straps changed");

    property p_handback;
        $rose(st_ff.phase == PH_HANDBACK) |->
            ##3 (st_ff.phase == PH_HANDBACK) ##1 (st_ff.phase == PH_RUN);
    endproperty
    a_handback: assert property (p_handback) else $error("handback timing");

    property p_no_drive;
        (st_ff.phase != PH_RUN) |-> (strap_pin_oe_out == 7'h00);
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("pins driven early");

    property p_boot_now;
        (st_ff.phase == PH_RUN && !boot_source_strap_out) |-> core_run_out;
    endproperty
    a_boot_now: assert property (p_boot_now) else $error("boot not started");

    property p_boot_wait;
        (boot_source_strap_out && !core_run_out && !ext_boot_in) |=> !core_run_out;
    endproperty
    a_boot_wait: assert property (p_boot_wait) else $error("boot without agent");

    property p_irq_mode;
        (st_ff.phase == PH_RUN) |-> (irq_enable_out == irq_edge_out) &&
            (!$rose(st_ff.phase == PH_RUN) ||
             irq_enable_out == $past(strap_pin_in[BUS_MASTER_PIN], 5));
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq mode wrong");

    property p_one_time;
        (wr_in && addr_in == SYSTEM_CONFIG_OFFSET && st_ff.sys_written &&
         !config_write_policy_strap_out) |=> $stable(system_config_reg_out);
    endproperty
    a_one_time: assert property (p_one_time) else $error("locked reg written");

    property p_run_pulls;
        (st_ff.phase == PH_RUN) |=> (pulldown_en_out == 7'h00) &&
            ((pullup_en_out & ~RUN_PULLUP_MASK) == 7'h00);
    endproperty
    a_run_pulls: assert property (p_run_pulls) else $error("run pulls wrong");

    property p_id_pulls;
        (proc_id_in != 3'h0) |=> ((pullup_en_out | pulldown_en_out) & ID_DEPENDENT_MASK) == 7'h00;
    endproperty
    a_id_pulls: assert property (p_id_pulls) else $error("id pulls on");

    property p_rst_pulls;
        (st_ff.phase == PH_RESET && proc_id_in == 3'h0) |=>
            (pulldown_en_out == RST_PULLDOWN_MASK) && (pullup_en_out == RST_PULLUP_MASK);
    endproperty
    a_rst_pulls: assert property (p_rst_pulls) else $error("reset pulls wrong");

    property p_mode_capture;
        $rose(st_ff.phase == PH_HANDBACK) |->
            (boot_source_strap_out == $past(strap_pin_in[BOOT_MEMORY_SELECT_PIN])) &&
            (link_rx_width_strap_out == $past(strap_pin_in[TIMER0_EXPIRED_PIN])) &&
            (config_write_policy_strap_out == $past(strap_pin_in[BUS_LOCK_PIN]));
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("mode straps wrong");

    property p_fault_capture;
        $rose(st_ff.phase == PH_HANDBACK) |-> test_strap_fault_out ==
            ((($past(strap_pin_in) ^ STRAP_DEFAULT) & TEST_STRAP_MASK) != 7'h00);
    endproperty
    a_fault_capture: assert property (p_fault_capture) else $error("test fault wrong");

    property p_no_early_write;
        (wr_in && st_ff.phase != PH_RUN) |=>
            $stable(system_config_reg_out) && $stable(sdram_config_reg_out);
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("early write taken");

    property p_always_wr;
        (wr_in && addr_in == SYSTEM_CONFIG_OFFSET && st_ff.phase == PH_RUN &&
         config_write_policy_strap_out) |=> (system_config_reg_out == $past(wdata_in));
    endproperty
    a_always_wr: assert property (p_always_wr) else $error("open reg not written");

    property p_sdr_one_time;
        (wr_in && addr_in == SDRAM_CONFIG_OFFSET && st_ff.sdr_written &&
         !config_write_policy_strap_out) |=> $stable(sdram_config_reg_out);
    endproperty
    a_sdr_one_time: assert property (p_sdr_one_time) else $error("sdram reg written");

    property p_run_sticky;
        core_run_out |=> core_run_out;
    endproperty
    a_run_sticky: assert property (p_run_sticky) else $error("core run dropped");

    property p_pins_run;
        (st_ff.phase == PH_RUN) |-> ((strap_pin_oe_out & RUN_DRIVEN_MASK) == RUN_DRIVEN_MASK);
    endproperty
    a_pins_run: assert property (p_pins_run) else $error("pins not driven");

    property p_pin_data;
        (st_ff.phase == PH_RUN) |=> (strap_pin_out == $past(func_data_in));
    endproperty
    a_pin_data: assert property (p_pin_data) else $error("pin data wrong");

    property p_hb_pulls;
        (st_ff.phase == PH_HANDBACK) |=> (pulldown_en_out == 7'h00);
    endproperty
    a_hb_pulls: assert property (p_hb_pulls) else $error("reset pulls kept");

    property p_id_zero_run;
        (st_ff.phase == PH_RUN && proc_id_in == 3'h0) |=> (pullup_en_out == RUN_PULLUP_MASK);
    endproperty
    a_id_zero_run: assert property (p_id_zero_run) else $error("run pull-ups off");

    c_boot_wait: cover property (boot_source_strap_out && $rose(core_run_out));
    c_always_wr: cover property (config_write_policy_strap_out && st_ff.sys_written &&
                                 wr_in && addr_in == SYSTEM_CONFIG_OFFSET);
    c_run: cover property ($rose(st_ff.phase == PH_RUN));
    c_lock_refused: cover property (!config_write_policy_strap_out && st_ff.sys_written &&
                                    wr_in && addr_in == SYSTEM_CONFIG_OFFSET);
    c_id_nonzero: cover property (st_ff.phase == PH_RUN && proc_id_in != 3'h0);

endmodule

// [rss_pkg.sv]
/*
  rss_pkg: constants for the reset strap sampler (pin indices, masks,
  register offsets, reset values, phase codes, hand-back timing).
  Assumes a 40 MHz system clock and a plain one-cycle register port.
*/
package rss_pkg;

    // ==========================================================
    // strap pin indices within the 7-bit pin vectors
    localparam int BOOT_MEMORY_SELECT_PIN = 0;
    localparam int BUS_MASTER_PIN = 1;
    localparam int TIMER0_EXPIRED_PIN = 2;
    localparam int BUS_LOCK_PIN = 3;
    localparam int LINK1_BLOCK_COMPLETE_OUT = 4;
    localparam int LINK2_BLOCK_COMPLETE_OUT = 5;
    localparam int LINK3_BLOCK_COMPLETE_OUT = 6;
    localparam int NUM_PINS = 7;

    // ==========================================================
    // pull and drive masks, bit i belongs to pin index i
    localparam logic [6:0] RST_PULLDOWN_MASK = 7'h0f;
    localparam logic [6:0] RST_PULLUP_MASK = 7'h70;
    localparam logic [6:0] RUN_PULLUP_MASK = 7'h09;
    localparam logic [6:0] ID_DEPENDENT_MASK = 7'h09;
    localparam logic [6:0] RUN_DRIVEN_MASK = 7'h76;
    localparam logic [6:0] TEST_STRAP_MASK = 7'h70;
    localparam logic [6:0] STRAP_DEFAULT = 7'h70;

    // ==========================================================
    // register port map and reset values
    localparam int ADDR_W = 8;
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] SYSTEM_CONFIG_OFFSET = 8'h04;
    localparam logic [7:0] SDRAM_CONFIG_OFFSET = 8'h08;
    localparam logic [31:0] SYSTEM_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] SDRAM_CONFIG_RESET = 32'h0000_0000;

    // ==========================================================
    // hand-back timing: least time from capture to normal pin use
    localparam int CLK_PERIOD_PS = 25000;
    localparam int HANDBACK_TIME_NS = 100;
    localparam int HANDBACK_CYCLES_I =
        (HANDBACK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] HANDBACK_LAST = 3'(HANDBACK_CYCLES_I - 1);

    // ==========================================================
    // phases of the sampler
    typedef enum logic [2:0] {
        PH_RESET = 3'h1,
        PH_HANDBACK = 3'h2,
        PH_RUN = 3'h4
    } rss_phase_t;

endpackage

// [rss_board_model.sv]
/*
  rss_board_model: board side of the strap pins, with external strap
  resistors, the internal pulls and the device drive resolved per pin.
  Assumes the bench commands which pins carry an external strap.
*/
`timescale 1ns/1ps
module rss_board_model (
    input wire logic clk_in,
    input wire logic [6:0] pin_out_in,
    input wire logic [6:0] pin_oe_in,
    input wire logic [6:0] pullup_en_in,
    input wire logic [6:0] pulldown_en_in,
    input wire logic [6:0] ext_en_in,
    input wire logic [6:0] ext_val_in,
    output logic [6:0] pin_level_out
);
    // ==========================================================
    // pin resolution
    logic [6:0] last_ff = 7'h00;

    always @(posedge clk_in) begin
        last_ff <= pin_level_out;
    end

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pin_oe_in[i]) begin
                pin_level_out[i] = pin_out_in[i];
            end else if (ext_en_in[i]) begin
                pin_level_out[i] = ext_val_in[i];
            end else if (pullup_en_in[i]) begin
                pin_level_out[i] = 1'b1;
            end else if (pulldown_en_in[i]) begin
                pin_level_out[i] = 1'b0;
            end else begin
                pin_level_out[i] = ~last_ff[i];
            end
        end
    end
endmodule

// [rss_reset_strap_sampler_tb_top.sv]
/*
  rss_reset_strap_sampler_tb_top: random strap, id and register traffic
  across repeated resets, checked against expected strap decoding.
  Assumes rss_pkg, the sampler and rss_board_model are compiled first.
*/
`timescale 1ns/1ps
module rss_reset_strap_sampler_tb_top
    import rss_pkg::*;
;
    // ==========================================================
    // signals
    logic clk_in, nrst_in, wr_in, rd_in, ext_boot_in;
    logic [6:0] strap_pin_in, strap_pin_out, strap_pin_oe_out, pullup_en_out, pulldown_en_out;
    logic [6:0] func_data_in, func_oe_in, ext_en, ext_val;
    logic [2:0] proc_id_in;
    logic boot_source_strap_out, irq_enable_out, irq_edge_out, core_run_out;
    logic link_rx_width_strap_out, config_write_policy_strap_out, test_strap_fault_out;
    logic [31:0] system_config_reg_out, sdram_config_reg_out, wdata_in, rdata_out;
    logic [ADDR_W-1:0] addr_in;
    int fails, checked, seed;

    rss_reset_strap_sampler DUT (.clk_in(clk_in), .nrst_in(nrst_in),
        .strap_pin_in(strap_pin_in), .strap_pin_out(strap_pin_out),
        .strap_pin_oe_out(strap_pin_oe_out), .pullup_en_out(pullup_en_out),
        .pulldown_en_out(pulldown_en_out), .proc_id_in(proc_id_in),
        .func_data_in(func_data_in), .func_oe_in(func_oe_in), .ext_boot_in(ext_boot_in),
        .core_run_out(core_run_out), .boot_source_strap_out(boot_source_strap_out),
        .irq_enable_out(irq_enable_out), .irq_edge_out(irq_edge_out),
        .link_rx_width_strap_out(link_rx_width_strap_out),
        .config_write_policy_strap_out(config_write_policy_strap_out),
        .test_strap_fault_out(test_strap_fault_out),
        .system_config_reg_out(system_config_reg_out),
        .sdram_config_reg_out(sdram_config_reg_out), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));

    rss_board_model board (.clk_in(clk_in), .pin_out_in(strap_pin_out),
        .pin_oe_in(strap_pin_oe_out), .pullup_en_in(pullup_en_out),
        .pulldown_en_in(pulldown_en_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .pin_level_out(strap_pin_in));

    // ==========================================================
    // compare, bus and closing tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask

    task automatic report_and_stop();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [6:0] levels(input logic [6:0] en, input logic [6:0] val);
        return (en & val) | (~en & STRAP_DEFAULT);
    endfunction

    // ==========================================================
    // one reset cycle with random straps
    task automatic run_case(input logic [2:0] id, input logic [6:0] en, input logic [6:0] val);
        logic [6:0] lv;
        logic [31:0] d1, d2, ex;
        logic flt;
        lv = levels(en, val);
        flt = ((lv & TEST_STRAP_MASK) !== TEST_STRAP_MASK);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        proc_id_in <= id;
        ext_en <= en;
        ext_val <= val;
        func_data_in <= 7'($random(seed));
        func_oe_in <= 7'($random(seed));
        repeat (20) @(posedge clk_in);
        #1;
        chk(32'(pullup_en_out), 32'h70);
        chk(32'(pulldown_en_out), (id == 3'h0) ? 32'h0f : 32'h06);
        chk(32'(strap_pin_oe_out), 32'h0);
        @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk(32'({test_strap_fault_out, config_write_policy_strap_out, link_rx_width_strap_out,
            irq_edge_out, irq_enable_out, boot_source_strap_out}),
            32'({flt, lv[3], lv[2], lv[1], lv[1], lv[0]}));
        ext_val <= ~val;
        wr(SYSTEM_CONFIG_OFFSET, 32'h0000_00a5);
        chk(system_config_reg_out, 32'h0);
        repeat (2) @(posedge clk_in);
        #1;
        chk(32'(core_run_out), 32'(!lv[0]));
        chk(32'(strap_pin_oe_out), 32'(RUN_DRIVEN_MASK | (func_oe_in & 7'h09)));
        chk(32'(strap_pin_out), 32'(func_data_in));
        chk(32'(pullup_en_out), (id == 3'h0) ? 32'h09 : 32'h0);
        chk(32'(pulldown_en_out), 32'h0);
        if (lv[0]) begin
            @(posedge clk_in);
            ext_boot_in <= 1'b1;
            @(posedge clk_in);
            ext_boot_in <= 1'b0;
            #1;
            chk(32'(core_run_out), 32'h1);
        end
        for (int k = 0; k < 2; k++) begin
            d1 = $random(seed);
            d2 = $random(seed);
            ex = lv[3] ? d2 : d1;
            wr(k ? SDRAM_CONFIG_OFFSET : SYSTEM_CONFIG_OFFSET, d1);
            wr(k ? SDRAM_CONFIG_OFFSET : SYSTEM_CONFIG_OFFSET, d2);
            chk(k ? sdram_config_reg_out : system_config_reg_out, ex);
            rd(k ? SDRAM_CONFIG_OFFSET : SYSTEM_CONFIG_OFFSET, ex);
        end
        rd(STATUS_OFFSET, 32'h780 | 32'(lv));
        rd(8'h0c, 32'h0);
        @(posedge clk_in);
        #1;
        chk(rdata_out, 32'h0);
    endtask

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        fails++;
        report_and_stop();
    end

    initial begin
        logic [2:0] id;
        logic [6:0] en, val;
        fails = 0;
        checked = 0;
        seed = 59;
        nrst_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        ext_boot_in = 1'b0;
        addr_in = '0;
        wdata_in = '0;
        proc_id_in = 3'h0;
        func_data_in = 7'h00;
        func_oe_in = 7'h00;
        ext_en = 7'h00;
        ext_val = 7'h00;
        for (int it = 0; it < 12; it++) begin
            id = (it == 0) ? 3'h0 : 3'($random(seed));
            en = (it == 0) ? 7'h00 : 7'($random(seed)) & 7'h0f;
            if (id != 3'h0) begin
                en = en | 7'h09;
            end
            val = 7'($random(seed));
            if (it == 11) begin
                en = en | 7'h10;
                val[4] = 1'b0;
            end
            run_case(id, en, val);
        end
        report_and_stop();
    end
endmodule
